// ### hw/rx_los_pkg.sv
// Shared constants for the receive loss-of-signal and output block
package rx_los_pkg;
  localparam int CH_NUM = 3;
  // Register byte offsets: channel n at n*CH_STRIDE
  localparam logic [7:0] CH_STRIDE = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] CONTROL_OFS = 8'h04;
  localparam logic [7:0] CONFIG_OFS = 8'h08;
  localparam logic [4:0] CONTROL_RST = 5'h00;
  localparam logic [4:0] CONFIG_RST = 5'h00;
  // Status bits
  localparam int ST_LOCK_LOSS = 4;
  localparam int ST_COMBINED = 3;
  localparam int ST_ANALOG = 2;
  localparam int ST_DIGITAL = 1;
  localparam int ST_DRIVE_MON = 0;
  // Control bits
  localparam int CT_ANALOG_OFF = 2;
  localparam int CT_DIGITAL_OFF = 1;
  // Receive configuration bits
  localparam int CF_MUTE = 3;
  localparam int CF_CLK_INV = 1;
  // Detector counts in bit periods, WIN_GOOD_NUM in windows
  localparam logic [7:0] ZERO_RUN = 8'ha0;
  localparam logic [4:0] WIN_LAST = 5'h1f;
  localparam logic [5:0] WIN_ONES_MIN = 6'h0a;
  localparam logic [2:0] WIN_GOOD_NUM = 3'h4;
  // Synchronised input vector layout
  localparam int IN_PER_CH = 6;
  localparam int IN_W = CH_NUM * IN_PER_CH + 3;
  localparam int IX_CLK = 0;
  localparam int IX_POS = 1;
  localparam int IX_NEG = 2;
  localparam int IX_ALOS = 3;
  localparam int IX_LOL = 4;
  localparam int IX_DMO = 5;
  localparam int IX_HOST = CH_NUM * IN_PER_CH;
  localparam int IX_GMUTE = IX_HOST + 1;
  localparam int IX_GINV = IX_HOST + 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : rx_los_pkg

// ### hw/rx_los_mute_out.sv
// Receive digital loss-of-signal, muting and dual-rail output for three channels
`timescale 1ns/1ps
module rx_los_mute_out (
  input wire logic clk_sys,
  input wire logic rst,
  // Line side, asynchronous
  input wire logic [rx_los_pkg::CH_NUM-1:0] line_clk_in,
  input wire logic [rx_los_pkg::CH_NUM-1:0] line_pos_in,
  input wire logic [rx_los_pkg::CH_NUM-1:0] line_neg_in,
  input wire logic [rx_los_pkg::CH_NUM-1:0] analog_signal_loss,
  input wire logic [rx_los_pkg::CH_NUM-1:0] recovery_lock_loss,
  input wire logic [rx_los_pkg::CH_NUM-1:0] drive_monitor_flag,
  input wire logic host_mode,
  input wire logic global_mute_on_loss_pin,
  input wire logic global_clock_invert_pin,
  // Terminal side
  output logic [rx_los_pkg::CH_NUM-1:0] positive_rail_out,
  output logic [rx_los_pkg::CH_NUM-1:0] negative_rail_out,
  output logic [rx_los_pkg::CH_NUM-1:0] recovered_clock_out,
  output logic [rx_los_pkg::CH_NUM-1:0] combined_signal_loss,
  output logic [rx_los_pkg::CH_NUM-1:0] rail_valid,
  input wire logic [rx_los_pkg::CH_NUM-1:0] rail_ready,
  output logic [rx_los_pkg::CH_NUM-1:0] line_ready,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int N = rx_los_pkg::CH_NUM;
  localparam int W = rx_los_pkg::IN_W;

  typedef struct packed {
    logic [W-1:0] s1, s2, s3, filt;
    logic [N-1:0] clk_prev;
    logic [N-1:0][7:0] zcnt;
    logic [N-1:0][4:0] wbit;
    logic [N-1:0][5:0] wones;
    logic [N-1:0][2:0] good;
    logic [N-1:0] dlos;
    logic [N-1:0][1:0][1:0] mem;
    logic [N-1:0][1:0] cnt;
    logic [N-1:0] pos_o, neg_o;
    logic [N-1:0][4:0] ctl, cfg;
    logic aw_held, w_held;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
  } state_t;

  state_t state_reg, state_next;
  logic [W-1:0] in_raw;
  logic [N-1:0] rise, one, mute, inv, a_loss;

  // Decode an address into channel and register slot
  function automatic logic [3:0] addr_dec(input logic [7:0] a);
    logic [3:0] r;
    r = 4'hf;
    if (a[7:4] < 4'(N) && a[1:0] == 2'h0 && a[3:0] <= rx_los_pkg::CONFIG_OFS[3:0])
      r = {a[5:4], a[3:2]};
    return r;
  endfunction : addr_dec

  // Pack asynchronous inputs for the synchroniser
  always_comb begin
    in_raw = '0;
    for (int c = 0; c < N; c++) begin
      in_raw[c*6+rx_los_pkg::IX_CLK] = line_clk_in[c];
      in_raw[c*6+rx_los_pkg::IX_POS] = line_pos_in[c];
      in_raw[c*6+rx_los_pkg::IX_NEG] = line_neg_in[c];
      in_raw[c*6+rx_los_pkg::IX_ALOS] = analog_signal_loss[c];
      in_raw[c*6+rx_los_pkg::IX_LOL] = recovery_lock_loss[c];
      in_raw[c*6+rx_los_pkg::IX_DMO] = drive_monitor_flag[c];
    end
    in_raw[rx_los_pkg::IX_HOST] = host_mode;
    in_raw[rx_los_pkg::IX_GMUTE] = global_mute_on_loss_pin;
    in_raw[rx_los_pkg::IX_GINV] = global_clock_invert_pin;
  end

  // Per-channel decode of filtered inputs and mode selects
  always_comb begin
    for (int c = 0; c < N; c++) begin
      rise[c] = state_reg.filt[c*6] & ~state_reg.clk_prev[c];
      one[c] = state_reg.filt[c*6+1] | state_reg.filt[c*6+2];
      a_loss[c] = state_reg.filt[c*6+3] & ~state_reg.ctl[c][rx_los_pkg::CT_ANALOG_OFF];
      mute[c] = state_reg.filt[rx_los_pkg::IX_HOST] ? state_reg.cfg[c][rx_los_pkg::CF_MUTE]
              : state_reg.filt[rx_los_pkg::IX_GMUTE];
      inv[c] = state_reg.filt[rx_los_pkg::IX_HOST] ? state_reg.cfg[c][rx_los_pkg::CF_CLK_INV]
             : state_reg.filt[rx_los_pkg::IX_GINV];
      combined_signal_loss[c] = a_loss[c] | state_reg.dlos[c];
      mute[c] = mute[c] & combined_signal_loss[c];
      rail_valid[c] = state_reg.cnt[c] != 2'h0;
      line_ready[c] = state_reg.cnt[c] != 2'h2;
      recovered_clock_out[c] = state_reg.clk_prev[c] ^ inv[c];
      positive_rail_out[c] = state_reg.pos_o[c];
      negative_rail_out[c] = state_reg.neg_o[c];
    end
    s_axi_awready = ~state_reg.aw_held;
    s_axi_wready = ~state_reg.w_held;
    s_axi_bvalid = state_reg.bvalid;
    s_axi_bresp = state_reg.bresp;
    s_axi_arready = ~state_reg.rvalid;
    s_axi_rvalid = state_reg.rvalid;
    s_axi_rresp = state_reg.rresp;
    s_axi_rdata = state_reg.rdata;
  end

  // Next-state logic
  always_comb begin
    logic [3:0] d;
    logic pop;
    logic [1:0] c_n;
    d = 4'h0;
    pop = 1'b0;
    c_n = 2'h0;
    state_next = state_reg;
    // Three-stage synchroniser, change accepted when stages two and three agree
    state_next.s1 = in_raw;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    state_next.filt = (state_reg.s2 & state_reg.s3) | (state_reg.filt & (state_reg.s2 ^ state_reg.s3));
    for (int c = 0; c < N; c++) begin
      state_next.clk_prev[c] = state_reg.filt[c*6];
      if (rise[c]) begin
        // Zero run towards declaration
        if (one[c])
          state_next.zcnt[c] = 8'h00;
        else if (state_reg.zcnt[c] != rx_los_pkg::ZERO_RUN)
          state_next.zcnt[c] = state_reg.zcnt[c] + 8'h01;
        if (!one[c] && state_reg.zcnt[c] == rx_los_pkg::ZERO_RUN - 8'h01)
          state_next.dlos[c] = 1'b1;
        // Density windows towards clearance
        state_next.wbit[c] = state_reg.wbit[c] + 5'h01;
        state_next.wones[c] = state_reg.wones[c] + {5'h00, one[c]};
        if (state_reg.wbit[c] == rx_los_pkg::WIN_LAST) begin
          state_next.wones[c] = 6'h00;
          if (state_reg.wones[c] + {5'h00, one[c]} >= rx_los_pkg::WIN_ONES_MIN) begin
            state_next.good[c] = state_reg.good[c] + 3'h1;
            if (state_reg.good[c] == rx_los_pkg::WIN_GOOD_NUM - 3'h1) begin
              state_next.dlos[c] = 1'b0;
              state_next.good[c] = 3'h0;
            end
          end else
            state_next.good[c] = 3'h0;
        end
        // Two-entry buffer: pop head to the rails, push the new bit pair
        pop = rail_ready[c] && state_reg.cnt[c] != 2'h0;
        if (pop) begin
          state_next.pos_o[c] = state_reg.mem[c][0][1] & ~mute[c];
          state_next.neg_o[c] = state_reg.mem[c][0][0] & ~mute[c];
          state_next.mem[c][0] = state_reg.mem[c][1];
        end
        c_n = state_reg.cnt[c] - {1'b0, pop};
        if (c_n != 2'h2) begin
          state_next.mem[c][c_n[0]] = {state_reg.filt[c*6+1], state_reg.filt[c*6+2]};
          c_n = c_n + 2'h1;
        end
        state_next.cnt[c] = c_n;
      end
      if (!state_reg.dlos[c] && !rise[c])
        state_next.good[c] = 3'h0;
      if (state_reg.ctl[c][rx_los_pkg::CT_DIGITAL_OFF])
        state_next.dlos[c] = 1'b0;
      if (mute[c]) begin
        state_next.pos_o[c] = 1'b0;
        state_next.neg_o[c] = 1'b0;
      end
    end
    // AXI4-Lite write path
    if (s_axi_awvalid && !state_reg.aw_held) begin
      state_next.aw_held = 1'b1;
      state_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state_reg.w_held) begin
      state_next.w_held = 1'b1;
      state_next.wdata = s_axi_wdata;
      state_next.wstrb = s_axi_wstrb;
    end
    if (state_reg.bvalid && s_axi_bready)
      state_next.bvalid = 1'b0;
    if (state_reg.aw_held && state_reg.w_held && !state_reg.bvalid) begin
      d = addr_dec(state_reg.awaddr);
      state_next.aw_held = 1'b0;
      state_next.w_held = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = d == 4'hf ? rx_los_pkg::RESP_DECERR : rx_los_pkg::RESP_OKAY;
      if (d != 4'hf && state_reg.wstrb[0]) begin
        if (d[1:0] == rx_los_pkg::CONTROL_OFS[3:2])
          state_next.ctl[d[3:2]] = state_reg.wdata[4:0];
        if (d[1:0] == rx_los_pkg::CONFIG_OFS[3:2])
          state_next.cfg[d[3:2]] = state_reg.wdata[4:0];
      end
    end
    // AXI4-Lite read path
    if (state_reg.rvalid && s_axi_rready)
      state_next.rvalid = 1'b0;
    if (s_axi_arvalid && !state_reg.rvalid) begin
      d = addr_dec(s_axi_araddr);
      state_next.rvalid = 1'b1;
      state_next.rresp = d == 4'hf ? rx_los_pkg::RESP_DECERR : rx_los_pkg::RESP_OKAY;
      state_next.rdata = 32'h0;
      if (d != 4'hf) begin
        if (d[1:0] == rx_los_pkg::STATUS_OFS[3:2]) begin
          state_next.rdata[rx_los_pkg::ST_LOCK_LOSS] = state_reg.filt[d[3:2]*6+4];
          state_next.rdata[rx_los_pkg::ST_COMBINED] = combined_signal_loss[d[3:2]];
          state_next.rdata[rx_los_pkg::ST_ANALOG] = state_reg.filt[d[3:2]*6+3];
          state_next.rdata[rx_los_pkg::ST_DIGITAL] = state_reg.dlos[d[3:2]];
          state_next.rdata[rx_los_pkg::ST_DRIVE_MON] = state_reg.filt[d[3:2]*6+5];
        end
        if (d[1:0] == rx_los_pkg::CONTROL_OFS[3:2])
          state_next.rdata[4:0] = state_reg.ctl[d[3:2]];
        if (d[1:0] == rx_los_pkg::CONFIG_OFS[3:2])
          state_next.rdata[4:0] = state_reg.cfg[d[3:2]];
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
      for (int c = 0; c < N; c++) begin
        state_reg.ctl[c] <= rx_los_pkg::CONTROL_RST;
        state_reg.cfg[c] <= rx_los_pkg::CONFIG_RST;
      end
    end else begin
      state_reg <= state_next;
    end
  end

  // Checks on channel 0
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence win_pass;
    rise[0] && state_reg.wbit[0] == 5'h1f && state_reg.wones[0] + {5'h00, one[0]} >= 6'h0a;
  endsequence
  sequence fourth_win;
    state_reg.good[0] == 3'h3 ##0 win_pass;
  endsequence

  AST_DECLARE: assert property (rise[0] && !one[0] && state_reg.zcnt[0] == 8'h9f
    && !state_reg.ctl[0][1] |=> state_reg.dlos[0]) else $error("zero run did not declare");
  AST_CLEAR: assert property (fourth_win |=> !state_reg.dlos[0])
    else $error("four good windows did not clear");
  AST_NO_EARLY_CLEAR: assert property (state_reg.dlos[0] && state_reg.good[0] < 3'h3
    && !state_reg.ctl[0][1] |=> state_reg.dlos[0]) else $error("cleared too early");
  AST_ZERO_RESTART: assert property (rise[0] && one[0] |=> state_reg.zcnt[0] == 8'h00)
    else $error("one did not restart run");
  AST_DIG_OFF: assert property (state_reg.ctl[0][1] |=> !state_reg.dlos[0])
    else $error("disabled detector declared");
  AST_BOTH_OFF: assert property ((state_reg.ctl[0][2] && state_reg.ctl[0][1]) [*2]
    |-> !combined_signal_loss[0]) else $error("loss with both detectors off");
  AST_COMBINED: assert property (combined_signal_loss[0] ==
    (state_reg.dlos[0] | (state_reg.filt[3] & !state_reg.ctl[0][2]))) else $error("combined wrong");
  AST_MUTE: assert property (mute[0] |=> !positive_rail_out[0] && !negative_rail_out[0])
    else $error("rails not muted");
  AST_LAUNCH: assert property ($changed(positive_rail_out[0]) |-> $past(rise[0]) || $past(mute[0]))
    else $error("rail moved off launch edge");
  AST_INV: assert property (recovered_clock_out[0] == (state_reg.clk_prev[0] ^
    (state_reg.filt[rx_los_pkg::IX_HOST] ? state_reg.cfg[0][1] : state_reg.filt[rx_los_pkg::IX_GINV])))
    else $error("clock polarity wrong");
endmodule : rx_los_mute_out

// ### verification/term_model.sv
// Terminal-side receiver model: samples rails, drives ready
`timescale 1ns/1ps
module term_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic rclk,
  input wire logic pos,
  input wire logic neg,
  input wire logic inv,
  input wire logic stall,
  output logic ready,
  output int pos_cnt,
  output int neg_cnt
);
  logic rclk_q;
  logic took;
  assign ready = !stall;
  // Count rail ones on the edge opposite to launch, only for words taken while ready
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rclk_q <= 1'b0;
      took <= 1'b0;
      pos_cnt <= 0;
      neg_cnt <= 0;
    end else begin
      rclk_q <= rclk;
      if (rclk_q != rclk && rclk != inv)
        took <= ready; // Launch edge
      if (rclk_q != rclk && rclk == inv && took) begin
        pos_cnt <= pos_cnt + int'(pos);
        neg_cnt <= neg_cnt + int'(neg);
      end
    end
  end
endmodule : term_model

// ### verification/tb.sv
// Testbench: registers, loss detection, muting and rail delivery
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] ST = rx_los_pkg::STATUS_OFS;
  localparam logic [7:0] CT = rx_los_pkg::CONTROL_OFS;
  localparam logic [7:0] CF = rx_los_pkg::CONFIG_OFS;
  localparam logic [1:0] OK = rx_los_pkg::RESP_OKAY;
  localparam logic [31:0] DIG = 32'h1 << rx_los_pkg::ST_DIGITAL;
  localparam logic [31:0] CMB = 32'h1 << rx_los_pkg::ST_COMBINED;
  localparam logic [31:0] ANA = 32'h1 << rx_los_pkg::ST_ANALOG;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic host_mode = 1'b1;
  logic gmute = 1'b0;
  logic ginv = 1'b0;
  logic [2:0] line_clk_in = '0, line_pos_in = '0, line_neg_in = '0;
  logic [2:0] alos = '0, lol = '0, dmo = '0, stall = '0, cinv = '0;
  logic [2:0] prail, nrail, rclk, closs, rready, lready, inv, rail_vld;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready_s = 1'b0;
  logic awready, wready, bvalid, arready, rvalid_s;
  logic [1:0] bresp, rresp;
  int pc [3];
  int nc [3];
  int num_errors = 0;
  int n_tests = 0;
  assign inv = host_mode ? cinv : {3{ginv}};
  always #5 clk_sys = ~clk_sys;
  rx_los_mute_out rx_los_mute_out_inst (.clk_sys, .rst, .line_clk_in, .line_pos_in, .line_neg_in,
    .analog_signal_loss(alos), .recovery_lock_loss(lol), .drive_monitor_flag(dmo), .host_mode,
    .global_mute_on_loss_pin(gmute), .global_clock_invert_pin(ginv), .positive_rail_out(prail),
    .negative_rail_out(nrail), .recovered_clock_out(rclk), .combined_signal_loss(closs), .rail_valid(rail_vld),
    .rail_ready(rready), .line_ready(lready), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid_s), .s_axi_rready(rready_s));
  // One terminal model per channel
  for (genvar g = 0; g < 3; g++) begin : g_term
    term_model term_model_inst (.clk_sys, .rst, .rclk(rclk[g]), .pos(prail[g]), .neg(nrail[g]),
      .inv(inv[g]), .stall(stall[g]), .ready(rready[g]), .pos_cnt(pc[g]), .neg_cnt(nc[g]));
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  function automatic logic [7:0] ad(input int ch, input logic [7:0] ofs);
    return rx_los_pkg::CH_STRIDE * 8'(ch) + ofs;
  endfunction : ad
  // Write: address and data offered together, each released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", er, bresp);
  endtask : wr
  // Read: response taken at the edge where rvalid is sampled high
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready_s <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid_s !== 1'b1);
    rready_s <= 1'b0;
    chk("rdata", e, rdata);
    chk("rresp", er, rresp);
  endtask : rd
  // Line bits at 160 ns per bit; ones alternate neg and pos pulses
  task automatic send(input int n, input int ch, input bit one);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      line_clk_in <= 3'h0;
      line_pos_in <= (one && i[0]) ? 3'h1 << ch : 3'h0;
      line_neg_in <= (one && !i[0]) ? 3'h1 << ch : 3'h0;
      repeat (8) @(posedge clk_sys);
      line_clk_in <= 3'h7;
      repeat (7) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    line_clk_in <= 3'h0;
    repeat (10) @(posedge clk_sys);
  endtask : send
  task automatic t_regs;
    rd(ad(0, CT), 32'(rx_los_pkg::CONTROL_RST), OK);
    rd(ad(2, CF), 32'(rx_los_pkg::CONFIG_RST), OK);
    wr(ad(1, CT), 32'hffffffff, OK);
    rd(ad(1, CT), 32'h1f, OK);
    wr(ad(1, CT), 32'h0, OK);
    wr(ad(1, ST), 32'h1f, OK);
    rd(ad(1, ST), 32'h0, OK);
    wr(8'h30, 32'h1, rx_los_pkg::RESP_DECERR);
    rd(8'h30, 32'h0, rx_los_pkg::RESP_DECERR);
  endtask : t_regs
  task automatic t_alarms;
    alos <= 3'h2;
    lol <= 3'h4;
    dmo <= 3'h4;
    repeat (10) @(posedge clk_sys);
    rd(ad(1, ST), ANA | CMB, OK);
    rd(ad(2, ST), 32'h11, OK);
    chk("closs", 3'h2, closs);
    wr(ad(1, CT), 32'h4, OK);
    chk("closs gated", 3'h0, closs);
    wr(ad(1, CT), 32'h0, OK);
    alos <= 3'h0;
    lol <= 3'h0;
    dmo <= 3'h0;
  endtask : t_alarms
  // Declare, mute, clear and resume on one channel
  task automatic t_los(input int ch, input bit hw);
    int p, q;
    if (hw) begin
      host_mode <= 1'b0;
      gmute <= 1'b1;
      ginv <= 1'b1;
    end else begin
      wr(ad(ch, CF), 32'ha, OK);
      cinv[ch] <= 1'b1;
    end
    send(160, ch, 1);
    rd(ad(ch, ST), 32'h0, OK);
    send(100, ch, 0);
    send(1, ch, 1);
    send(159, ch, 0);
    rd(ad(ch, ST), 32'h0, OK);
    send(1, ch, 0);
    rd(ad(ch, ST), DIG | CMB, OK);
    chk("closs los", 1'b1, closs[ch]);
    p = pc[ch];
    q = nc[ch];
    send(60, ch, 1);
    rd(ad(ch, ST), DIG | CMB, OK);
    chk("muted pos", p, pc[ch]);
    chk("muted neg", q, nc[ch]);
    send(100, ch, 1);
    rd(ad(ch, ST), 32'h0, OK);
    p = pc[ch];
    q = nc[ch];
    send(8, ch, 1);
    chk("pos resumed", 1'b1, pc[ch] > p);
    chk("neg resumed", 1'b1, nc[ch] > q);
    chk("clk idle", 1'b1, rclk[ch]);
    host_mode <= 1'b1;
    gmute <= 1'b0;
    ginv <= 1'b0;
  endtask : t_los
  task automatic t_off;
    wr(ad(0, CT), 32'h2, OK);
    alos <= 3'h1;
    send(170, 0, 0);
    rd(ad(0, ST), ANA | CMB, OK);
    chk("closs dig off", 1'b1, closs[0]);
    wr(ad(0, CT), 32'h6, OK);
    rd(ad(0, ST), ANA, OK);
    chk("closs off", 1'b0, closs[0]);
    alos <= 3'h0;
  endtask : t_off
  // Receiver stall fills the two-entry buffer
  task automatic t_buf;
    int p;
    p = pc[2];
    stall <= 3'h4;
    send(3, 2, 1);
    chk("buffer full", 1'b0, lready[2]);
    chk("rail valid", 1'b1, rail_vld[2]);
    stall <= 3'h0;
    send(4, 2, 1);
    // The line cannot pause, so each pop is matched by a push and the level stays at two
    chk("buffer level", 1'b0, lready[2]);
    chk("rail valid out", 1'b1, rail_vld[2]);
    chk("words out", 1'b1, pc[2] > p);
  endtask : t_buf
  task automatic conclude;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs;
    t_alarms;
    t_los(0, 1'b0);
    t_los(1, 1'b1);
    t_off;
    t_buf;
    conclude;
  end
  // Watchdog
  initial begin
    repeat (60000) @(posedge clk_sys);
    num_errors++;
    conclude;
  end
endmodule : tb
